// >>> src/asfpc_converter.sv
// Converter end: frames conversions, shifts result, tracks power state.
// Assumes select and serial clock come from the host's domain.
`timescale 1ns/1ps
`include "asfpc_defines.svh"

module asfpc_converter
#(
    parameter int RES_BITS = `ASFPC_RESULT_BITS
)
(
    // Clock and reset.
    input  wire logic                i_clock,
    input  wire logic                i_sys_rst,
    // Link.
    asfpc_link_if.converter          link,
    // Analog stand-in and status.
    input  wire logic [RES_BITS-1:0] i_sample,
    input  wire logic                i_short_mode,
    output logic                     o_powered,
    output logic                     o_result_valid
);

    // ----------------------------------------------------------------
    // Frame timeline
    // ----------------------------------------------------------------
    // Select and serial clock come from the host's domain. Each one
    // passes two synchroniser flops and one edge register, so every link
    // edge takes effect three system clocks after it reaches the wire.
    // The synchronisers reset to the idle level of their pins, so the
    // release of reset never looks like a select or clock fall.
    // A select fall opens a frame. The input word is held, the frame
    // mode is latched and the pin drives the leading zero at once.
    // Each serial clock fall then moves the pin on by one bit. The first
    // fall shows the MSB, the twelfth fall shows the LSB, and later falls
    // show trailing zeros, so a host sampling on rising edges sees the
    // leading zero and the twelve result bits on its first thirteen
    // rises.
    // A select rise after two to nine counted falls cuts the conversion
    // short. The pin is let go and the part drops into power-down.
    // A later select rise ends the frame normally. A full frame lets go
    // of the pin, and a short frame keeps driving it until the next one.
    // The host raises select on the same wire edge as its last clock
    // fall. Both reach the edge detectors together and the rise wins, so
    // the last fall is never counted here. The abort window is therefore
    // judged on the falls seen before the rise.
    // A part that sleeps treats its next frame as a dummy. The bits it
    // shifts carry no result, and the tenth fall wakes it, so the wake
    // time scales with the serial clock period.
    // A released pin shows the inverse of its last trailing zero. A host
    // that samples the pin before the leading zero reads a wrong bit.

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    // True when a frame that ends after this many falls must be cut short.
    function automatic logic in_abort_window(input logic [`ASFPC_CNT_WIDTH-1:0] count);
        in_abort_window = (count >= `ASFPC_CNT_WIDTH'(`ASFPC_ABORT_FIRST)) &&
                          (count <  `ASFPC_CNT_WIDTH'(`ASFPC_KEEP_FALLS));
    endfunction : in_abort_window

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                   sel_sync;   // Select synchroniser.
        logic [1:0]                   clk_sync;   // Clock synchroniser.
        logic                         sel_q;      // Last synced select.
        logic                         clk_q;      // Last synced clock.
        logic                         in_frame;   // Frame open.
        logic [`ASFPC_CNT_WIDTH-1:0]  falls;      // Falling edges in frame.
        logic [RES_BITS-1:0]          held;       // Sampled value.
        asfpc_pkg::asfpc_power_type   power;      // Power state.
        logic                         valid;      // Current frame valid.
        logic                         dout;       // Data pin.
        logic                         dout_oe;    // Data enable.
        logic                         short_q;    // Short mode latched.
        logic                         powered;    // Power-ready flag.
    } asfpc_conv_state_type;

    asfpc_conv_state_type state;       // Registered state.
    asfpc_conv_state_type next_state;  // Next state.
    logic                 sel_fall;    // Select fell.
    logic                 sel_rise;    // Select rose.
    logic                 clk_fall;    // Serial clock fell.

    // Edge detectors read only the second synchroniser stage.
    assign sel_fall = state.sel_q & ~state.sel_sync[1];
    assign sel_rise = ~state.sel_q & state.sel_sync[1];
    assign clk_fall = state.clk_q & ~state.clk_sync[1];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state          = state;
        next_state.sel_sync = {state.sel_sync[0], link.sel_n};
        next_state.clk_sync = {state.clk_sync[0], link.sclk};
        next_state.sel_q    = state.sel_sync[1];
        next_state.clk_q    = state.clk_sync[1];
        if (sel_fall)
        begin
            // New frame samples input and starts conversion. (see RULE_10)
            next_state.in_frame = 1'b1;
            next_state.falls    = '0;
            next_state.held     = i_sample;
            next_state.short_q  = i_short_mode; // (see RULE_05)
            // Only a powered part yields a valid result. (see RULE_02) (see RULE_03)
            next_state.valid    = (state.power == asfpc_pkg::PWR_READY);
            if (state.power == asfpc_pkg::PWR_DOWN)
            begin
                // Wake ends at the tenth fall of the dummy frame. (see RULE_04)
                next_state.power = asfpc_pkg::PWR_WAKE;
            end
            next_state.dout     = 1'b0;  // Leading zero. (see RULE_11)
            next_state.dout_oe  = 1'b1;
        end
        else if (sel_rise && state.in_frame)
        begin
            next_state.in_frame = 1'b0;
            if (in_abort_window(state.falls))
            begin
                // Early rise aborts and powers down. (see RULE_13)
                next_state.power   = asfpc_pkg::PWR_DOWN;
                next_state.valid   = 1'b0;
                next_state.dout    = 1'b1;
                next_state.dout_oe = 1'b0;
            end
            else if (!state.short_q)
            begin
                // A full frame lets go of the pin at its end. (see RULE_12)
                next_state.dout    = 1'b1;
                next_state.dout_oe = 1'b0;
            end
            else
            begin
                // Short mode keeps driving between frames. (see RULE_06)
                next_state.dout_oe = 1'b1;
            end
        end
        else if (clk_fall && state.in_frame)
        begin
            next_state.falls = state.falls + `ASFPC_CNT_WIDTH'(1);
            if (state.falls == `ASFPC_CNT_WIDTH'(`ASFPC_KEEP_FALLS - 1) &&
                state.power == asfpc_pkg::PWR_WAKE)
            begin
                // Dummy frame long enough: powered up. (see RULE_01) (see RULE_04)
                next_state.power = asfpc_pkg::PWR_READY;
            end
            if (state.falls < `ASFPC_CNT_WIDTH'(RES_BITS))
            begin
                // MSB on second cycle, LSB on thirteenth. (see RULE_11)
                next_state.dout = state.held[RES_BITS - 1 - 32'(state.falls)];
            end
            else
            begin
                next_state.dout = 1'b0;  // Trailing zeros. (see RULE_11)
            end
            if (state.falls == `ASFPC_CNT_WIDTH'(`ASFPC_FULL_CLOCKS - 1) && !state.short_q)
            begin
                // Release output in the sixteenth cycle. (see RULE_12)
                next_state.dout    = 1'b1;
                next_state.dout_oe = 1'b0;
            end
        end
        // The ready flag follows the power state, so the port needs no gate.
        next_state.powered = (next_state.power == asfpc_pkg::PWR_READY);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state          <= '0;
            state.sel_sync <= 2'h3;
            state.sel_q    <= 1'b1;
            // Clock edge history starts at the high level the host drives in reset.
            state.clk_sync <= 2'h3;
            state.clk_q    <= 1'b1;
            state.power    <= asfpc_pkg::PWR_DOWN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a state flop, with no gate behind it.
    assign link.dout      = state.dout;
    assign link.dout_oe   = state.dout_oe;
    assign o_powered      = state.powered;
    assign o_result_valid = state.valid;

endmodule : asfpc_converter

// >>> src/asfpc_defines.svh
// Constants for the serial converter framing and power control block.
// Assumes inclusion by bare name from the package and both ends.
// Notes on behaviour
// RULE_01 - Wake needs dummy frame, ten clocks low.
// RULE_02 - Dummy frame output bits are invalid.
// RULE_03 - First frame after dummy is valid.
// RULE_04 - Power-up time equals dummy frame length.
// RULE_05 - Short frame of fourteen clocks supported.
// RULE_06 - Short mode never releases data output; an aborted frame still releases it.
// RULE_07 - Host leaves settling gap between frames.
// RULE_08 - Host may slow clock, staying powered.
// RULE_09 - Host may power down between conversions.
// RULE_10 - Select fall samples, converts, opens frame.
// RULE_11 - Leading zero, MSB clock 2, LSB 13.
// RULE_12 - Full frame releases output at clock 16.
// RULE_13 - Early select rise aborts, enters power-down.
// RULE_14 - Short frame host ignores final trailing bit.
`ifndef ASFPC_DEFINES_SVH
`define ASFPC_DEFINES_SVH

// ----------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------
`define ASFPC_RESULT_BITS   12
`define ASFPC_FULL_CLOCKS   16
`define ASFPC_SHORT_CLOCKS  14
`define ASFPC_MSB_CLOCK     2
`define ASFPC_KEEP_FALLS    10
`define ASFPC_ABORT_FIRST   2
`define ASFPC_LINK_DIV      4
`define ASFPC_GAP_CYCLES    8
`define ASFPC_CNT_WIDTH     5

`endif

// >>> src/asfpc_host.sv
// Host end: makes select and serial clock, captures results.
// Assumes the converter drives data on serial clock falling edges.
`timescale 1ns/1ps
`include "asfpc_defines.svh"

module asfpc_host
#(
    parameter int RES_BITS = `ASFPC_RESULT_BITS,
    parameter int DIV      = `ASFPC_LINK_DIV,
    parameter int GAP      = `ASFPC_GAP_CYCLES
)
(
    // Clock and reset.
    input  wire logic                i_clock,
    input  wire logic                i_sys_rst,
    // Link.
    asfpc_link_if.host               link,
    // User side.
    input  wire logic                i_start,
    input  wire logic                i_short_mode,
    input  wire logic                i_power_down,
    output logic                     o_busy,
    output logic [RES_BITS-1:0]      o_data,
    output logic                     o_data_valid
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        asfpc_pkg::asfpc_host_type    phase;     // Host phase.
        logic [1:0]                   din_sync;  // Data synchroniser.
        logic [7:0]                   div;       // Clock divider.
        logic [`ASFPC_CNT_WIDTH-1:0]  cycles;    // Clocks in frame.
        logic [`ASFPC_CNT_WIDTH-1:0]  limit;     // Clocks this frame.
        logic [RES_BITS:0]            shift;     // Zero plus result.
        logic [7:0]                   gap;       // Acquisition gap.
        logic                         sel_n;     // Select pin.
        logic                         sclk;      // Clock pin.
        logic                         dummy;     // Frame is dummy.
        logic                         asleep;    // Converter powered down.
        logic [RES_BITS-1:0]          data;      // Result.
        logic                         data_v;    // Result pulse.
        logic                         busy;      // Not idle.
    } asfpc_host_state_type;

    asfpc_host_state_type state;       // Registered state.
    asfpc_host_state_type next_state;  // Next state.

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state          = state;
        next_state.din_sync = {state.din_sync[0], link.dout};
        next_state.data_v   = 1'b0;
        unique case (state.phase)
            asfpc_pkg::HOST_IDLE:
            begin
                // A held power-down request keeps a sleeping part asleep until a start. (see RULE_09)
                if (i_start || (state.asleep && !i_power_down))
                begin
                    // Sleeping part gets a dummy frame first. (see RULE_01)
                    next_state.dummy  = state.asleep;
                    next_state.phase  = asfpc_pkg::HOST_FRAME;
                    next_state.sel_n  = 1'b0;
                    next_state.cycles = '0;
                    next_state.div    = '0;
                    // Abort early to sleep between samples. (see RULE_09)
                    next_state.limit  = (i_power_down && !state.asleep) ?
                        `ASFPC_CNT_WIDTH'(`ASFPC_ABORT_FIRST + 1) :
                        (i_short_mode ? `ASFPC_CNT_WIDTH'(`ASFPC_SHORT_CLOCKS) :
                                        `ASFPC_CNT_WIDTH'(`ASFPC_FULL_CLOCKS)); // (see RULE_05)
                end
            end
            asfpc_pkg::HOST_FRAME:
            begin
                // Slower divider lowers rate while powered. (see RULE_08)
                next_state.div = state.div + 8'h01;
                if (state.div == 8'(DIV - 1))
                begin
                    next_state.div  = '0;
                    next_state.sclk = ~state.sclk;
                    if (!state.sclk)
                    begin
                        // Rising edge: capture bit. (see RULE_14)
                        // Rises after falls one to thirteen hold the leading zero and the result.
                        if (state.cycles >= `ASFPC_CNT_WIDTH'(1) &&
                            state.cycles <= `ASFPC_CNT_WIDTH'(RES_BITS + 1))
                        begin
                            next_state.shift = {state.shift[RES_BITS-1:0], state.din_sync[1]};
                        end
                    end
                    else
                    begin
                        next_state.cycles = state.cycles + `ASFPC_CNT_WIDTH'(1);
                        if (state.cycles == state.limit - `ASFPC_CNT_WIDTH'(1))
                        begin
                            next_state.sel_n  = 1'b1;
                            next_state.phase  = asfpc_pkg::HOST_GAP;
                            next_state.gap    = '0;
                            next_state.asleep = (state.limit < `ASFPC_CNT_WIDTH'(`ASFPC_KEEP_FALLS));
                            // Dummy frame data is discarded. (see RULE_02)
                            if (!state.dummy && state.limit >= `ASFPC_CNT_WIDTH'(`ASFPC_KEEP_FALLS))
                            begin
                                next_state.data   = state.shift[RES_BITS-1:0];
                                next_state.data_v = 1'b1;
                            end
                        end
                    end
                end
            end
            asfpc_pkg::HOST_GAP:
            begin
                // Settling gap before next select fall. (see RULE_07)
                next_state.gap = state.gap + 8'h01;
                if (state.gap == 8'(GAP - 1))
                begin
                    next_state.phase = asfpc_pkg::HOST_IDLE;
                end
            end
        endcase
        // Busy flag is registered, so the port comes straight from a flop.
        next_state.busy = (next_state.phase != asfpc_pkg::HOST_IDLE);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state        <= '0;
            state.phase  <= asfpc_pkg::HOST_IDLE;
            state.sel_n  <= 1'b1;
            state.sclk   <= 1'b1;
            state.asleep <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign link.sel_n   = state.sel_n;
    assign link.sclk    = state.sclk;
    assign o_busy       = state.busy;
    assign o_data       = state.data;
    assign o_data_valid = state.data_v;

endmodule : asfpc_host

// >>> src/asfpc_link_if.sv
// Three-wire link joining the host end and the converter end.
// Assumes the bench resolves the data wire from its enable.
`timescale 1ns/1ps

interface asfpc_link_if;
    logic sel_n;     // Chip select, active low.
    logic sclk;      // Serial clock made by the host.
    logic dout;      // Data driven by the converter.
    logic dout_oe;   // High while the converter drives data.

    modport converter (input sel_n, input sclk, output dout, output dout_oe);
    modport host      (output sel_n, output sclk, input dout, input dout_oe);
endinterface : asfpc_link_if

// >>> src/asfpc_pkg.sv
// Types shared by both ends of the serial converter link.
// Assumes the defines header is on the include path.
`include "asfpc_defines.svh"

package asfpc_pkg;

    // Power state of the converter end.
    typedef enum logic [2:0]
    {
        PWR_DOWN  = 3'h1,
        PWR_WAKE  = 3'h2,
        PWR_READY = 3'h4
    } asfpc_power_type;

    // Phase of the host end.
    typedef enum logic [2:0]
    {
        HOST_IDLE  = 3'h1,
        HOST_FRAME = 3'h2,
        HOST_GAP   = 3'h4
    } asfpc_host_type;

endpackage : asfpc_pkg

// >>> tb/adc_serial_frame_power_control_bench.sv
// Bench driving the host end against the converter end.
// Assumes both ends, the link and the checker compile first.
`timescale 1ns/1ps

module adc_serial_frame_power_control_bench;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic        clock;      // System clock, 40 MHz.
    logic        sys_rst;    // Reset, active high.
    logic        start;      // Frame request.
    logic        short_mode; // Fourteen clock frames.
    logic        power_down; // Next frame sleeps.
    logic [11:0] sample;     // Value to convert.
    logic        busy;       // Host busy.
    logic        powered;    // Converter awake.
    logic        res_valid;  // Converter frame valid.
    logic        data_valid; // Result pulse.
    logic [11:0] data;       // Result word.
    logic        got;        // A result was seen.
    logic [11:0] got_data;   // Last result seen.
    int          err_total;
    int          compares;
    logic [11:0] vals [4] = '{12'hA5C, 12'h000, 12'hFFF, 12'h801};

    asfpc_link_if link();

    asfpc_host u_asfpc_host (.i_clock(clock), .i_sys_rst(sys_rst), .link(link), .i_start(start),
        .i_short_mode(short_mode), .i_power_down(power_down), .o_busy(busy), .o_data(data),
        .o_data_valid(data_valid));
    asfpc_converter u_asfpc_converter (.i_clock(clock), .i_sys_rst(sys_rst), .link(link),
        .i_sample(sample), .i_short_mode(short_mode), .o_powered(powered), .o_result_valid(res_valid));
    asfpc_checker u_asfpc_checker (.i_clock(clock), .i_sys_rst(sys_rst), .i_short_mode(short_mode),
        .sel_n(link.sel_n), .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe));

    // Clock with a 25 ns period.
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Catches the one-cycle result pulse.
    always @(posedge clock)
    begin
        if (data_valid === 1'b1)
        begin
            got      <= 1'b1;
            got_data <= data;
        end
    end

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    // Compares one flag.
    task check_bit(input logic act, input logic exp);
        compares++;
        if (act !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t flag is %b, expected %b", $time, act, exp);
        end
    endtask : check_bit

    // Compares one result word.
    task check_word(input logic [11:0] act, input logic [11:0] exp);
        compares++;
        if (act !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t word is %h, expected %h", $time, act, exp);
        end
    endtask : check_word

    // Waits for the host to go idle after its gap, then twelve more cycles.
    task wait_idle;
        int n;
        n = 0;
        while ((busy !== 1'b0 || link.sel_n !== 1'b1) && n < 4000)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 4000)
        begin
            err_total++;
            $display("[FAIL] %0t host never went idle", $time);
            finish_test();
        end
        repeat (12) @(negedge clock);
    endtask : wait_idle

    // Requests one frame and waits for it to finish.
    task run(input logic mode, input logic [11:0] val);
        short_mode = mode;
        sample     = val;
        got        = 1'b0;
        start      = 1'b1;
        @(negedge clock);
        start = 1'b0;
        @(negedge clock);
        wait_idle();
    endtask : run

    // Prints the counts and the verdict, then ends the run.
    task finish_test;
        $display("errors %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial
    begin
        {start, short_mode, power_down, got} = 4'h0;
        sample    = 12'h000;
        got_data  = 12'h000;
        err_total = 0;
        compares  = 0;
        sys_rst   = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        // The host wakes the converter with a dummy frame by itself.
        repeat (2) @(negedge clock);
        wait_idle();
        check_bit(got, 1'b0);
        check_bit(powered, 1'b1);
        // Full and short frames over boundary values.
        for (int m = 0; m < 2; m++)
        begin
            foreach (vals[i])
            begin
                run(m[0], vals[i]);
                check_bit(got, 1'b1);
                check_word(got_data, vals[i]);
                check_bit(res_valid, 1'b1);
                check_bit(link.dout_oe, m[0]);
            end
        end
        // Back to a full frame after short ones.
        run(1'b0, 12'h7E1);
        check_word(got_data, 12'h7E1);
        check_bit(link.dout_oe, 1'b0);
        // Aborted frame puts the converter to sleep.
        power_down = 1'b1;
        run(1'b0, 12'h3C3);
        power_down = 1'b0;
        check_bit(got, 1'b0);
        check_bit(powered, 1'b0);
        check_bit(link.dout_oe, 1'b0);
        // Wake again, then a valid result.
        run(1'b0, 12'h5A5);
        check_bit(got, 1'b0);
        check_bit(powered, 1'b1);
        run(1'b0, 12'h69C);
        check_bit(got, 1'b1);
        check_word(got_data, 12'h69C);
        finish_test();
    end

    // Cuts a hang short well past the expected run length.
    initial
    begin
        repeat (40000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule : adc_serial_frame_power_control_bench

// >>> tb/asfpc_checker.sv
// Checker for the link between the host and converter ends.
// Assumes the bench wires it to the link and the shared mode input.
`timescale 1ns/1ps

module asfpc_checker
(
    // Clock, reset and mode.
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_short_mode,
    // Link.
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe
);
    // ------------------------------------------------
    // Helper logic
    // ------------------------------------------------
    logic [4:0] falls;  // Serial clock falls in this frame.
    logic       sclk_q; // Serial clock one cycle ago.
    logic       sel_q;  // Select one cycle ago.

    // Counts falls made while select was low, including the last fall,
    // which lands with the rise of select; clears when select falls.
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            falls  <= 5'h00;
            sclk_q <= 1'b1;
            sel_q  <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk;
            sel_q  <= sel_n;
            if (sel_q && !sel_n)
                falls <= 5'h00;
            else if (!sel_q && sclk_q && !sclk)
                falls <= falls + 5'h01;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    a_gap_after_frame: assert property ($rose(sel_n) |-> sel_n [*8])
        else $error("Select fell inside the gap.");
    a_sclk_idle_still: assert property (sel_n [*6] |-> $stable(sclk))
        else $error("Serial clock moved outside a frame.");
    a_sclk_half_period: assert property (!sel_n && $changed(sclk) |=> $stable(sclk) [*3])
        else $error("Serial clock half period too short.");
    a_full_release: assert property ($rose(sel_n) && !i_short_mode |-> ##[1:6] !dout_oe)
        else $error("Full frame kept driving data.");
    a_short_keeps_drive: assert property (i_short_mode && sel_n && dout_oe |=> dout_oe)
        else $error("Short mode released data.");
    a_frame_length: assert property ($rose(sel_n) |=>
        falls inside {[5'h02:5'h09]} || falls == (i_short_mode ? 5'h0E : 5'h10))
        else $error("Frame had a wrong count of clocks.");
    a_abort_release: assert property ($rose(sel_n) && falls < 5'h0A |-> ##[1:6] !dout_oe)
        else $error("Aborted frame kept driving data.");
    a_drive_in_frame: assert property ($fell(sel_n) |-> ##[1:12] dout_oe)
        else $error("Frame opened without driving data.");
endmodule : asfpc_checker
